// File: clock_module_event_control.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module clock_module_event_control
  import clock_event_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // detector events, from pins of other blocks
  input  wire logic        ref_fail_in,
  input  wire logic        ts_tx_underrun_in,
  input  wire logic        ts_tx_overrun_in,
  input  wire logic        ts_rx_underrun_in,
  input  wire logic        ts_rx_overrun_in,
  input  wire logic        cell_loss_in,
  input  wire logic        out_of_sync_in,
  // outputs
  output logic             global_timing_service,
  output logic             holdover_output,
  output logic             counter_snapshot,
  output logic             acr_receive_enable,
  output logic             irq
);
  logic [EVT_N-1:0] raw_in;
  logic [EVT_N-1:0] sync1;
  logic [EVT_N-1:0] sync2;
  logic [EVT_N-1:0] sync3;
  logic [7:0]       ctrl;
  logic [1:0]       holdover_output_sel;
  logic [EVT_N-1:0] status;
  logic [EVT_N-1:0] irq_en;
  assign raw_in = {out_of_sync_in, cell_loss_in, ts_rx_overrun_in, ts_rx_underrun_in,
                   ts_tx_overrun_in, ts_tx_underrun_in, ref_fail_in};
  // two-flop synchroniser, third stage only for out-of-sync edge detection
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  logic [15:0]      rd_word;

  // one address compare shared by every register decode
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] reg_addr);
    return addr == reg_addr;
  endfunction : addr_is

  // apb decode; zero-wait slave, unmapped addresses answer with pslverr
  wire access   = psel && penable;
  wire setup    = psel && !penable;
  wire wr       = access && pwrite && pstrb[0];
  wire hit_ctrl = addr_is(paddr, CTRL_ADDR);
  wire hit_stat = addr_is(paddr, STAT_ADDR);
  wire hit_en   = addr_is(paddr, IRQ_EN_ADDR);
  wire hit_clr  = addr_is(paddr, IRQ_CLR_ADDR);
  wire hit_fr   = addr_is(paddr, HOLDOVER_OUTPUT_ADDR);
  wire mapped   = hit_ctrl | hit_stat | hit_en | hit_clr | hit_fr;
  wire wr_ctrl  = wr && hit_ctrl;
  wire wr_fr    = wr && hit_fr;
  wire wr_en    = wr && hit_en;
  wire wr_clr   = wr && (hit_stat || hit_clr);
  wire snap_req = wr_ctrl && pwdata[B_SNAP];
  wire [EVT_N-1:0] clr_mask = wr_clr ? pwdata[EVT_N-1:0] : '0;

  // event qualification
  wire [EVT_N-1:0] evt;
  assign evt[E_REF]    = sync2[E_REF];
  assign evt[E_TXU]    = sync2[E_TXU];
  assign evt[E_TXO]    = sync2[E_TXO];
  assign evt[E_RXU]    = sync2[E_RXU];
  assign evt[E_RXO]    = sync2[E_RXO];
  assign evt[E_LOSS]   = sync2[E_LOSS] && ctrl[B_ACR];
  // edge only, so a machine that stays out of sync does not refill a cleared flag
  assign evt[E_DESYNC] = sync2[E_DESYNC] && !sync3[E_DESYNC];

  // set wins over clear, so an event in the clearing cycle is not lost
  wire [EVT_N-1:0] next_status = (status & ~clr_mask) | evt;

  wire service = (ctrl[B_REF] && status[E_REF])
              || (ctrl[B_TS_TX] && (status[E_TXU] || status[E_TXO]))
              || (ctrl[B_TS_RX] && (status[E_RXU] || status[E_RXO]))
              || (ctrl[B_LOSS] && status[E_LOSS])
              || (ctrl[B_DESYNC] && status[E_DESYNC]);
  wire holdover_next = status[E_REF] && (holdover_output_sel == HOLDOVER_OUTPUT_ON_FAIL);
  wire irq_next      = |(status & irq_en);

  always_comb
  begin
    rd_word = '0;
    if (hit_ctrl)
      rd_word = {8'h00, ctrl};
    else if (hit_stat)
      rd_word = {|status, 8'h00, status};
    else if (hit_en)
      rd_word = {9'h000, irq_en};
    else if (hit_fr)
      rd_word = {14'h0000, holdover_output_sel};
  end

  // status flags, one flop per event
  genvar gi;
  generate
    for (gi = 0; gi < EVT_N; gi++)
    begin : g_flag
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
          status[gi] <= 1'b0;
        end
        else
        begin
          status[gi] <= next_status[gi];
        end
    end
  endgenerate

  // control register; reserved bit 4 never stored
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl <= pwdata[7:0] & CTRL_WMASK;
    end

  // free-run field standing in for the master clock generation control
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      holdover_output_sel <= HOLDOVER_OUTPUT_RESET;
    end
    else if (wr_fr)
    begin
      holdover_output_sel <= pwdata[1:0];
    end

  // interrupt enables
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_en <= '0;
    end
    else if (wr_en)
    begin
      irq_en <= pwdata[EVT_N-1:0];
    end

  // snapshot is a one-cycle pulse; the stored bit itself drives nothing
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      counter_snapshot <= 1'b0;
    end
    else
    begin
      counter_snapshot <= snap_req;
    end

  // global timing service
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      global_timing_service <= 1'b0;
    end
    else
    begin
      global_timing_service <= service;
    end

  // free-run output
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      holdover_output <= 1'b0;
    end
    else
    begin
      holdover_output <= holdover_next;
    end

  // receive circuit enable
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      acr_receive_enable <= 1'b0;
    end
    else
    begin
      acr_receive_enable <= ctrl[B_ACR];
    end

  // level interrupt
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_next;
    end

  // ready is registered from setup, so every access has exactly one cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= setup;
    end

  // error response for unmapped addresses
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= setup && !mapped;
    end

  // read data, zero outside the access cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata <= '0;
    end
    else
    begin
      prdata <= setup ? {16'h0000, rd_word} : '0;
    end

  snapshot_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    counter_snapshot |=> !counter_snapshot) else $error("snapshot longer than one cycle");
  snap_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    snap_req |=> counter_snapshot) else $error("snapshot pulse missing");
  flag_held_a: assert property (@(posedge pclk) disable iff (!presetn)
    evt[E_REF] |=> status[E_REF]) else $error("ref fail event lost");
  service_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[B_REF] && status[E_REF]) |=> global_timing_service) else $error("service missing");
  service_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[B_TS_TX] && (status[E_TXU] || status[E_TXO])) |=> global_timing_service)
    else $error("tx service missing");
  service_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[B_TS_RX] && (status[E_RXU] || status[E_RXO])) |=> global_timing_service)
    else $error("rx service missing");
  service_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[B_LOSS] && status[E_LOSS]) |=> global_timing_service) else $error("loss service missing");
  service_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[B_DESYNC] && status[E_DESYNC]) |=> global_timing_service) else $error("sync service missing");
  service_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !service |=> !global_timing_service) else $error("service without enabled flag");
  ref_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    sync2[E_REF] |=> status[E_REF]) else $error("ref fail not latched");
  txu_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    sync2[E_TXU] |=> status[E_TXU]) else $error("tx underrun not latched");
  txo_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    sync2[E_TXO] |=> status[E_TXO]) else $error("tx overrun not latched");
  rxu_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    sync2[E_RXU] |=> status[E_RXU]) else $error("rx underrun not latched");
  rxo_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    sync2[E_RXO] |=> status[E_RXO]) else $error("rx overrun not latched");
  loss_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sync2[E_LOSS] && ctrl[B_ACR]) |=> status[E_LOSS]) else $error("cell loss not latched");
  desync_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sync2[E_DESYNC] && sync3[E_DESYNC] && !status[E_DESYNC]) |=> !status[E_DESYNC])
    else $error("desync set without edge");
  loss_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl[B_ACR] && !status[E_LOSS]) |=> !status[E_LOSS]) else $error("loss while disabled");
  clear_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_mask[E_TXU] && !evt[E_TXU]) |=> !status[E_TXU]) else $error("clear failed");
  zero_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
    (status[E_RXO] && !clr_mask[E_RXO]) |=> status[E_RXO]) else $error("flag lost without clear");
  pend_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_stat && (|status)) |=> prdata[B_PEND]) else $error("pending bit missing");
  pend_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_stat && !(|status)) |=> !prdata[B_PEND]) else $error("pending bit without flag");
  holdover_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    (status[E_REF] && holdover_output_sel == HOLDOVER_OUTPUT_ON_FAIL) |=> holdover_output) else $error("no holdover");
  holdover_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !holdover_next |=> !holdover_output) else $error("holdover without cause");
  acr_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    acr_receive_enable == $past(ctrl[B_ACR])) else $error("acr enable mismatch");
  ctrl_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl & ~CTRL_WMASK) == 8'h00) else $error("reserved bit stored");
  ctrl_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_ctrl) |=> prdata[15:8] == 8'h00) else $error("upper control bits not zero");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_next |=> irq) else $error("interrupt missing");
  ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready longer than one cycle");
endmodule : clock_module_event_control

// File: clock_event_pkg.sv
// How it works
// - ref-fail flag with enable bit 0 raises the global timing-service output.
// - tx underrun or overrun flag with enable bit 1 raises global service.
// - writing one to bit 2 pulses a counter snapshot; stored level ignored.
// - rx underrun or overrun flag with enable bit 3 raises global service.
// - reserved bit 4 written as zero by software; bits 15:8 read zero.
// - cell-loss flag with enable bit 5 raises global service.
// - out-of-sync flag with enable bit 6 raises global service.
// - control bit 7 enables the adaptive recovery receive circuit.
// - status bit 0 latches on reference clock failure.
// - ref-fail flag with free-run field 01 drives the holdover output.
// - status bit 1 latches on transmit time-stamp underrun.
// - status bit 2 latches on transmit time-stamp overrun.
// - status bit 3 latches on receive time-stamp underrun.
// - status bit 4 latches on receive time-stamp overrun.
// - status bit 5 latches on timing cell loss while receive enabled.
// - status bit 6 latches only on entry into out-of-sync.
// - writing one clears a status flag; writing zero leaves it.
// - status bit 15 reads one whenever any of bits 6:0 is set.
package clock_event_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          EVT_N           = 7;
  localparam logic [15:0] CTRL_ADDR       = 16'h6080;
  localparam logic [15:0] STAT_ADDR       = 16'h6082;
  localparam logic [15:0] IRQ_EN_ADDR     = 16'h6084;
  localparam logic [15:0] IRQ_CLR_ADDR    = 16'h6086;
  localparam logic [15:0] HOLDOVER_OUTPUT_ADDR    = 16'h6090;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_WMASK      = 8'hEF;
  localparam logic [1:0]  HOLDOVER_OUTPUT_RESET   = 2'h0;
  localparam logic [1:0]  HOLDOVER_OUTPUT_ON_FAIL = 2'h1;
  localparam int          B_REF           = 0;
  localparam int          B_TS_TX         = 1;
  localparam int          B_SNAP          = 2;
  localparam int          B_TS_RX         = 3;
  localparam int          B_LOSS          = 5;
  localparam int          B_DESYNC        = 6;
  localparam int          B_ACR           = 7;
  localparam int          E_REF           = 0;
  localparam int          E_TXU           = 1;
  localparam int          E_TXO           = 2;
  localparam int          E_RXU           = 3;
  localparam int          E_RXO           = 4;
  localparam int          E_LOSS          = 5;
  localparam int          E_DESYNC        = 6;
  localparam int          B_PEND          = 15;
endpackage : clock_event_pkg

// File: testbench.sv
`timescale 1ns/1ps
module testbench
  import clock_event_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, slverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic [6:0]  ev;
  logic        pready, pslverr, global_timing_service, holdover_output, counter_snapshot, acr_receive_enable, irq;
  int          err_count, cmp_count, snaps, s0;
  int          enb [7] = '{0, 1, 1, 3, 3, 5, 6};
  clock_module_event_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .ref_fail_in(ev[0]), .ts_tx_underrun_in(ev[1]), .ts_tx_overrun_in(ev[2]),
    .ts_rx_underrun_in(ev[3]), .ts_rx_overrun_in(ev[4]), .cell_loss_in(ev[5]), .out_of_sync_in(ev[6]),
    .global_timing_service, .holdover_output, .counter_snapshot, .acr_receive_enable, .irq);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // snapshot pulses are one cycle wide, so count them rather than look at one edge
  always @(posedge pclk) if (counter_snapshot === 1'b1) snaps <= snaps + 1;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n == 50)
    begin
      err_count++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rdat = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rdat);
  endtask : rd
  task automatic t_regs;
    rd(CTRL_ADDR, 32'h0000_0000, "ctrl reset");
    rd(STAT_ADDR, 32'h0000_0000, "status reset");
    s0 = snaps;
    apb(1'b1, CTRL_ADDR, 32'hFFFF_FFFF);
    rd(CTRL_ADDR, 32'h0000_00EF, "ctrl mask");
    chk("acr on", 1, acr_receive_enable);
    apb(1'b1, CTRL_ADDR, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk("snap count", 1, snaps - s0);
    chk("acr off", 0, acr_receive_enable);
    rd(16'h6088, 32'h0000_0000, "unmapped data");
    chk("unmapped", 1, slverr);
    ev[5] <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(STAT_ADDR, 32'h0000_0000, "loss gated");
    ev[5] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : t_regs
  task automatic t_irq;
    apb(1'b1, HOLDOVER_OUTPUT_ADDR, 32'h0000_0001);
    apb(1'b1, IRQ_EN_ADDR, 32'h0000_0001);
    ev[0] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("holdover", 1, holdover_output);
    chk("irq", 1, irq);
    apb(1'b1, IRQ_CLR_ADDR, 32'h0000_0001);
    rd(STAT_ADDR, 32'h0000_8001, "set wins");
    ev[0] <= 1'b0;
    apb(1'b1, HOLDOVER_OUTPUT_ADDR, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk("holdover field", 0, holdover_output);
    apb(1'b1, IRQ_EN_ADDR, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk("irq masked", 0, irq);
    apb(1'b1, IRQ_CLR_ADDR, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    rd(STAT_ADDR, 32'h0000_0000, "clear reg");
  endtask : t_irq
  task automatic t_event(input int i);
    apb(1'b1, CTRL_ADDR, 32'h0000_0080);
    ev[i] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("service masked", 0, global_timing_service);
    rd(STAT_ADDR, 32'h0000_8000 | (1 << i), "flag set");
    apb(1'b1, CTRL_ADDR, 32'h0000_0080 | (1 << enb[i]));
    repeat (3) @(posedge pclk);
    chk("service", 1, global_timing_service);
    // the sync flag must not re-latch while its input simply stays high
    if (i != 6) ev[i] <= 1'b0;
    apb(1'b1, STAT_ADDR, 32'h0000_007F ^ (1 << i));
    rd(STAT_ADDR, 32'h0000_8000 | (1 << i), "zero keeps");
    apb(1'b1, STAT_ADDR, 1 << i);
    rd(STAT_ADDR, 32'h0000_0000, "cleared");
    ev[i] <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("service off", 0, global_timing_service);
  endtask : t_event
  task automatic end_of_test;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial
  begin
    {presetn, psel, penable, pwrite, ev, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_irq;
    for (int i = 0; i < EVT_N; i++) t_event(i);
    end_of_test;
  end
  initial
  begin
    #100us;
    err_count++;
    end_of_test;
  end
endmodule : testbench
